// >>> hdl/tfm_pkg.sv
// traverse frequency modulator: shared constants, register map and types
// assumes a 25 MHz system clock and a plain one-cycle register port
package tfm_pkg;
  // ************************************************************
  // register map (word index on the register port)
  // ************************************************************
  localparam logic [3:0] ADDR_MODE = 4'h0;      // function selector
  localparam logic [3:0] ADDR_AMPL = 4'h1;      // swing amplitude, 0.1 percent units
  localparam logic [3:0] ADDR_SCRAMBLE = 4'h2;  // jump size, 0.1 percent units
  localparam logic [3:0] ADDR_ACC = 4'h3;       // upswing time, 0.1 s units
  localparam logic [3:0] ADDR_DEC = 4'h4;       // downswing time, 0.1 s units
  localparam logic [3:0] ADDR_UPPER = 4'h5;     // upper_shift_percent, 0.1 percent
  localparam logic [3:0] ADDR_LOWER = 4'h6;     // lower_shift_percent, 0.1 percent
  localparam logic [3:0] ADDR_TERM0 = 4'h7;     // input_terminal_function of the terminal chosen by ADDR_TERMSEL
  localparam logic [3:0] ADDR_FREF = 4'h8;      // frequency reference
  localparam logic [3:0] ADDR_FOUT = 4'h9;      // output frequency, read only
  localparam logic [3:0] ADDR_STATUS = 4'ha;    // phase and shift-terminal flag, read only
  localparam logic [3:0] ADDR_TERMSEL = 4'hb;   // terminal table index
  // ************************************************************
  // codes, limits and defaults
  // ************************************************************
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_TRAVERSE = 3'h1;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [7:0] TERM_SHIFT_LOW = 8'h1b;   // code 27
  localparam logic [7:0] TERM_SHIFT_HIGH = 8'h1c;  // code 28
  localparam logic [15:0] AMPL_MAX = 16'h00c8;     // 20.0 percent
  localparam logic [15:0] SCRAMBLE_MAX = 16'h01f4; // 50.0 percent
  localparam logic [15:0] SHIFT_MAX = 16'h00c8;    // 20.0 percent
  localparam logic [15:0] TIME_MIN = 16'h0001;     // 0.1 s
  localparam logic [15:0] TIME_MAX = 16'h1770;     // 600.0 s
  localparam logic [15:0] ACC_DEFAULT = 16'h0014;  // 2.0 s
  localparam logic [15:0] DEC_DEFAULT = 16'h001e;  // 3.0 s
  localparam logic [15:0] PERMILLE = 16'h03e8;     // 1000 = 100.0 percent
  // time base: one tenth of a second in clock cycles
  localparam int CLK_HZ = 25000000;
  localparam int TENTH_S_MS = 100;
  localparam int TENTH_CYCLES = CLK_HZ / 1000 * TENTH_S_MS;
  // swing phases, gray coded along idle-up-down
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_UP = 2'b01, PH_DOWN = 2'b11} tfm_phase_e;
endpackage

// >>> hdl/tfm_step_if.sv
// traverse frequency modulator: link between swing control and step engine
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface tfm_step_if;
  logic tick;          // one rate step due
  logic [15:0] period; // cycles between steps
  logic clear;         // restart the step timer
  // ************************************************************
  // modports
  // ************************************************************
  modport ctrl (input tick, output period, output clear);
  modport timer (output tick, input period, input clear);
endinterface
`default_nettype wire

// >>> hdl/tfm_step_timer.sv
// traverse frequency modulator: step pacing timer
// assumes period is held stable while no clear is given
`timescale 1ns/1ns
`default_nettype none
module tfm_step_timer #(
  parameter int CW = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control side
  tfm_step_if.timer stp
);
  logic [CW-1:0] cnt_q, cnt_d;

  // one tick every period cycles, so a ramp lasts its set time; period zero or one ticks each cycle
  always_comb begin
    stp.tick = ((cnt_q + CW'(1)) >= CW'(stp.period)) && !stp.clear;
    cnt_d = cnt_q + CW'(1);
    if (stp.clear || stp.tick) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tfm_traverse.sv
// traverse frequency modulator: register port, terminal decode and swing engine
// assumes synchronous terminal inputs and a one-cycle register read latency
`timescale 1ns/1ns
`default_nettype none
module tfm_traverse #(
  parameter int NTERM = 11,
  parameter int FW = 16,
  parameter int TENTH = tfm_pkg::TENTH_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // terminals and drive stage
  input wire logic [NTERM-1:0] termIn,
  output logic [FW-1:0] freqOut,
  output logic traverseActive
);
  // ************************************************************
  // settings registers
  // ************************************************************
  logic [2:0] mode_q, mode_d;
  logic [15:0] ampl_q, ampl_d, scr_q, scr_d, acc_q, acc_d, dec_q, dec_d;
  logic [15:0] upper_q, upper_d, lower_q, lower_d, fref_q, fref_d;
  logic [7:0] termFn_q [NTERM], termFn_d [NTERM];
  logic [3:0] termSel_q, termSel_d;
  logic [15:0] rdata_q, rdata_d;
  logic enTrv;

  // saturate a write at the legal range
  function automatic logic [15:0] clampVal(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign enTrv = (mode_q == tfm_pkg::MODE_TRAVERSE);

  // register writes; traverse settings only accept writes in traverse mode
  always_comb begin
    mode_d = mode_q;
    ampl_d = ampl_q;
    scr_d = scr_q;
    acc_d = acc_q;
    dec_d = dec_q;
    upper_d = upper_q;
    lower_d = lower_q;
    fref_d = fref_q;
    termSel_d = termSel_q;
    termFn_d = termFn_q;
    if (regWr) begin
      case (regAddr)
        tfm_pkg::ADDR_MODE: mode_d = (regWdata > 16'(tfm_pkg::MODE_MAX)) ? mode_q : regWdata[2:0];
        tfm_pkg::ADDR_AMPL: if (enTrv) ampl_d = clampVal(regWdata, '0, tfm_pkg::AMPL_MAX);
        tfm_pkg::ADDR_SCRAMBLE: if (enTrv) scr_d = clampVal(regWdata, '0, tfm_pkg::SCRAMBLE_MAX);
        tfm_pkg::ADDR_ACC: if (enTrv) acc_d = clampVal(regWdata, tfm_pkg::TIME_MIN, tfm_pkg::TIME_MAX);
        tfm_pkg::ADDR_DEC: if (enTrv) dec_d = clampVal(regWdata, tfm_pkg::TIME_MIN, tfm_pkg::TIME_MAX);
        tfm_pkg::ADDR_UPPER: if (enTrv) upper_d = clampVal(regWdata, '0, tfm_pkg::SHIFT_MAX);
        tfm_pkg::ADDR_LOWER: if (enTrv) lower_d = clampVal(regWdata, '0, tfm_pkg::SHIFT_MAX);
        tfm_pkg::ADDR_TERM0: if (termSel_q < 4'(NTERM)) termFn_d[termSel_q] = regWdata[7:0];
        tfm_pkg::ADDR_FREF: fref_d = regWdata;
        tfm_pkg::ADDR_TERMSEL: termSel_d = regWdata[3:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // terminal decode
  // ************************************************************
  logic shiftUp, shiftDn;
  // any terminal carrying the code raises or lowers; several may share one code
  always_comb begin
    shiftUp = 1'b0;
    shiftDn = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (termIn[i] && termFn_q[i] == tfm_pkg::TERM_SHIFT_HIGH) shiftUp = 1'b1;
      if (termIn[i] && termFn_q[i] == tfm_pkg::TERM_SHIFT_LOW) shiftDn = 1'b1;
    end
  end

  // ************************************************************
  // swing targets
  // ************************************************************
  logic [31:0] amplF, upF, dnF, baseF, hiF, loF, spanF, scrF;
  always_comb begin
    amplF = (32'(fref_q) * 32'(ampl_q)) / 32'(tfm_pkg::PERMILLE);
    upF = (32'(fref_q) * 32'(upper_q)) / 32'(tfm_pkg::PERMILLE);
    dnF = (32'(fref_q) * 32'(lower_q)) / 32'(tfm_pkg::PERMILLE);
    baseF = 32'(fref_q) + (shiftUp ? upF : 32'h0);
    baseF = (shiftDn && baseF > dnF) ? baseF - dnF : (shiftDn ? 32'h0 : baseF);
    hiF = baseF + amplF;
    loF = (baseF > amplF) ? baseF - amplF : 32'h0;
    spanF = hiF - loF;
    // jump measured against the operating amplitude, not the clipped span
    scrF = (amplF * 32'(scr_q)) / 32'(tfm_pkg::PERMILLE);
  end

  // ************************************************************
  // swing engine
  // ************************************************************
  tfm_step_if stp();
  tfm_step_timer u_timer (.mclk(mclk), .sys_rst(sys_rst), .stp(stp));

  tfm_pkg::tfm_phase_e ph_q, ph_d;
  logic [31:0] f_q, f_d;
  logic [47:0] per;

  // one step of one frequency unit per tick; full span in the set ramp time
  always_comb begin
    per = (48'(ph_q == tfm_pkg::PH_DOWN ? dec_q : acc_q) * 48'(TENTH)) / ((spanF == 0) ? 48'h1 : 48'(spanF));
    stp.period = (per > 48'h0000_0000_ffff) ? 16'hffff : per[15:0];
  end

  always_comb begin
    ph_d = ph_q;
    f_d = f_q;
    stp.clear = 1'b0;
    case (ph_q)
      tfm_pkg::PH_IDLE: begin
        f_d = baseF;
        if (enTrv) begin
          ph_d = tfm_pkg::PH_UP;
          stp.clear = 1'b1;
        end
      end
      tfm_pkg::PH_UP: begin
        if (!enTrv) begin
          ph_d = tfm_pkg::PH_IDLE;
        end else if (f_q >= hiF) begin
          ph_d = tfm_pkg::PH_DOWN;
          f_d = (hiF > scrF) ? hiF - scrF : 32'h0;
          stp.clear = 1'b1;
        end else if (stp.tick) begin
          f_d = f_q + 32'h1;
        end
      end
      tfm_pkg::PH_DOWN: begin
        if (!enTrv) begin
          ph_d = tfm_pkg::PH_IDLE;
        end else if (f_q <= loF) begin
          ph_d = tfm_pkg::PH_UP;
          stp.clear = 1'b1;
        end else if (stp.tick) begin
          f_d = f_q - 32'h1;
        end
      end
      default: ph_d = tfm_pkg::PH_IDLE;
    endcase
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_comb begin
    rdata_d = 16'h0000;
    if (regRd) begin
      case (regAddr)
        tfm_pkg::ADDR_MODE: rdata_d = {13'h0000, mode_q};
        tfm_pkg::ADDR_AMPL: rdata_d = enTrv ? ampl_q : 16'h0000;
        tfm_pkg::ADDR_SCRAMBLE: rdata_d = enTrv ? scr_q : 16'h0000;
        tfm_pkg::ADDR_ACC: rdata_d = enTrv ? acc_q : 16'h0000;
        tfm_pkg::ADDR_DEC: rdata_d = enTrv ? dec_q : 16'h0000;
        tfm_pkg::ADDR_UPPER: rdata_d = enTrv ? upper_q : 16'h0000;
        tfm_pkg::ADDR_LOWER: rdata_d = enTrv ? lower_q : 16'h0000;
        tfm_pkg::ADDR_TERM0: rdata_d = (termSel_q < 4'(NTERM)) ? {8'h00, termFn_q[termSel_q]} : 16'h0000;
        tfm_pkg::ADDR_FREF: rdata_d = fref_q;
        tfm_pkg::ADDR_FOUT: rdata_d = f_q[15:0];
        tfm_pkg::ADDR_STATUS: rdata_d = {13'h0000, shiftDn || shiftUp, ph_q};
        tfm_pkg::ADDR_TERMSEL: rdata_d = {12'h000, termSel_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // all state but the step timer count registered here; reset gives defaults
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= tfm_pkg::MODE_NONE;
      ampl_q <= '0;
      scr_q <= '0;
      acc_q <= tfm_pkg::ACC_DEFAULT;
      dec_q <= tfm_pkg::DEC_DEFAULT;
      upper_q <= '0;
      lower_q <= '0;
      fref_q <= '0;
      termSel_q <= '0;
      for (int i = 0; i < NTERM; i++) termFn_q[i] <= '0;
      rdata_q <= '0;
      ph_q <= tfm_pkg::PH_IDLE;
      f_q <= '0;
    end else begin
      mode_q <= mode_d;
      ampl_q <= ampl_d;
      scr_q <= scr_d;
      acc_q <= acc_d;
      dec_q <= dec_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      fref_q <= fref_d;
      termSel_q <= termSel_d;
      termFn_q <= termFn_d;
      rdata_q <= rdata_d;
      ph_q <= ph_d;
      f_q <= f_d;
    end
  end

  assign regRdata = rdata_q;
  assign freqOut = f_q[FW-1:0];
  assign traverseActive = (ph_q != tfm_pkg::PH_IDLE);
endmodule
`default_nettype wire

// >>> tb/tb.sv
// traverse frequency modulator: self-checking bench
// assumes the package, design, drive model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic clearStats = 1'h0;
  logic traverseActive;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata, freqOut, fMax, fMin, maxDrop;
  logic [10:0] termIn;
  logic [10:0] press = 11'h000;
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;
  // short tenth-second so a whole swing fits in about a thousand cycles; up and down rates still differ
  tfm_traverse #(.NTERM(11), .FW(16), .TENTH(20)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .termIn(termIn),
    .freqOut(freqOut), .traverseActive(traverseActive));
  tfm_drive_model #(.NTERM(11), .FW(16)) u_model (.mclk(mclk), .press(press), .clearStats(clearStats),
    .fMax(fMax), .fMin(fMin), .maxDrop(maxDrop), .freqOut(freqOut), .traverseActive(traverseActive),
    .termIn(termIn));
  initial begin
    forever #20 mclk = ~mclk;
  end
  // hang guard, far above the two thousand or so cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'h0;
    #1;
    chk(regRdata, exp);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_defaults();
    rdchk(tfm_pkg::ADDR_MODE, 16'h0000);
    wr(tfm_pkg::ADDR_AMPL, 16'h0010);
    rdchk(tfm_pkg::ADDR_AMPL, 16'h0000);
    rdchk(4'hf, 16'h0000);
    wr(tfm_pkg::ADDR_MODE, 16'h0001);
    rdchk(tfm_pkg::ADDR_AMPL, 16'h0000);
    rdchk(tfm_pkg::ADDR_ACC, 16'h0014);
    rdchk(tfm_pkg::ADDR_DEC, 16'h001e);
  endtask
  // each setting written past its limit must saturate at it
  task automatic t_limits();
    logic [15:0] w [6] = '{16'h012c, 16'h0258, 16'h0000, 16'h1b58, 16'h00fa, 16'h00fa};
    logic [15:0] e [6] = '{16'h00c8, 16'h01f4, 16'h0001, 16'h1770, 16'h00c8, 16'h00c8};
    for (int i = 0; i < 6; i++) begin
      wr(4'(i + 1), w[i]);
      rdchk(4'(i + 1), e[i]);
    end
  endtask
  // base 1000, amplitude 10 percent (100), jump 10 percent of that amplitude
  // up: 20 tenths * 20 / 200 = 2 cycles a unit; down: 30 * 20 / 200 = 3 cycles a unit
  task automatic t_swing();
    logic [15:0] w [6] = '{16'h0064, 16'h0064, 16'h0014, 16'h001e, 16'h0032, 16'h001e};
    for (int i = 0; i < 6; i++) begin
      wr(4'(i + 1), w[i]);
    end
    wr(tfm_pkg::ADDR_FREF, 16'h03e8);
    wr(tfm_pkg::ADDR_MODE, 16'h0000);
    repeat (8) @(posedge mclk);
    wr(tfm_pkg::ADDR_MODE, 16'h0001);
    repeat (4) @(posedge mclk);
    clearStats <= 1'h1;
    @(posedge mclk);
    clearStats <= 1'h0;
    repeat (45) @(posedge mclk);
    #1;
    chk(freqOut, 16'h0400);
    repeat (20) @(posedge mclk);
    #1;
    chk(freqOut, 16'h040a);
    repeat (230) @(posedge mclk);
    #1;
    chk(freqOut, 16'h0422);
    repeat (30) @(posedge mclk);
    #1;
    chk(freqOut, 16'h0418);
    repeat (1200) @(posedge mclk);
    #1;
    chk(fMax, 16'h044c);
    chk(fMin, 16'h0384);
    chk(maxDrop, 16'h000a);
  endtask
  task automatic t_codes();
    for (int m = 0; m < 5; m++) begin
      wr(tfm_pkg::ADDR_MODE, 16'(m));
      repeat (4) @(posedge mclk);
      #1;
      chk({15'h0000, traverseActive}, {15'h0000, m == 1});
      rdchk(tfm_pkg::ADDR_MODE, 16'(m));
    end
    wr(tfm_pkg::ADDR_MODE, 16'h0007);
    rdchk(tfm_pkg::ADDR_MODE, 16'h0004);
  endtask
  // idle base follows the shift terminals: +50 on terminal 3, -30 on terminal 10
  task automatic t_offsets();
    logic [10:0] pat [4] = '{11'h000, 11'h008, 11'h400, 11'h408};
    logic [15:0] fx [4] = '{16'h03e8, 16'h041a, 16'h03ca, 16'h03fc};
    wr(tfm_pkg::ADDR_TERMSEL, 16'h000a);
    wr(tfm_pkg::ADDR_TERM0, {8'h00, tfm_pkg::TERM_SHIFT_LOW});
    wr(tfm_pkg::ADDR_TERMSEL, 16'h000b);
    wr(tfm_pkg::ADDR_TERM0, {8'h00, tfm_pkg::TERM_SHIFT_HIGH});
    wr(tfm_pkg::ADDR_TERMSEL, 16'h000a);
    rdchk(tfm_pkg::ADDR_TERM0, 16'h001b);
    wr(tfm_pkg::ADDR_TERMSEL, 16'h0003);
    wr(tfm_pkg::ADDR_TERM0, {8'h00, tfm_pkg::TERM_SHIFT_HIGH});
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      press <= pat[i];
      repeat (6) @(posedge mclk);
      #1;
      chk(freqOut, fx[i]);
      rdchk(tfm_pkg::ADDR_STATUS, (i == 0) ? 16'h0000 : 16'h0004);
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    t_defaults();
    t_limits();
    t_swing();
    t_codes();
    t_offsets();
    close_out();
  end
endmodule
`default_nettype wire

// >>> tb/tfm_drive_model.sv
// traverse frequency modulator: drive stage and terminal contacts model
// assumes the bench sets contact levels and reads back the swing extremes
`timescale 1ns/1ns
`default_nettype none
module tfm_drive_model #(
  parameter int NTERM = 11,
  parameter int FW = 16
) (
  // clock
  input wire logic mclk,
  // bench side
  input wire logic [NTERM-1:0] press,
  input wire logic clearStats,
  output logic [FW-1:0] fMax,
  output logic [FW-1:0] fMin,
  output logic [FW-1:0] maxDrop,
  // device side
  input wire logic [FW-1:0] freqOut,
  input wire logic traverseActive,
  output logic [NTERM-1:0] termIn
);
  logic [FW-1:0] lastF;
  // contacts move on the clock so the block sees synchronous levels; extremes only while swinging
  always @(posedge mclk) begin
    termIn <= press;
    lastF <= freqOut;
    if (clearStats) begin
      fMax <= '0;
      fMin <= '1;
      maxDrop <= '0;
    end else if (traverseActive) begin
      if (freqOut > fMax) fMax <= freqOut;
      if (freqOut < fMin) fMin <= freqOut;
      if (lastF > freqOut && lastF - freqOut > maxDrop) maxDrop <= lastF - freqOut;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tfm_traverse_props.sv
// traverse frequency modulator: port-level property checker
// assumes it is bound onto tfm_traverse and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module tfm_traverse_props #(
  parameter int NTERM = 11,
  parameter int FW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // terminals and drive stage
  input wire logic [NTERM-1:0] termIn,
  input wire logic [FW-1:0] freqOut,
  input wire logic traverseActive
);
  logic [15:0] modeQ;
  logic [15:0] modeD;
  logic modeWr;
  logic rdSet;
  // shadow of the selector; codes above the top one are dropped, as the block must
  assign modeWr = regWr && regAddr == tfm_pkg::ADDR_MODE;
  assign rdSet = regRd && modeQ == 16'h0001;
  always_comb begin
    modeD = modeQ;
    if (modeWr && regWdata <= 16'h0004) begin
      modeD = regWdata;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      modeQ <= 16'h0000;
    end else begin
      modeQ <= modeD;
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_rd_idle; !regRd |=> regRdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_rd_gate; regRd && modeQ != 16'h0001 && regAddr inside {[4'h1:4'h6]} |=> regRdata == 16'h0000; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("setting visible outside traverse");
  property p_start; modeWr && regWdata == 16'h0001 && modeQ != 16'h0001 |-> ##[1:3] traverseActive; endproperty
  a_start: assert property (p_start) else $error("swing did not start");
  property p_stop; modeWr && regWdata == 16'h0000 |-> ##3 (!traverseActive) [*4]; endproperty
  a_stop: assert property (p_stop) else $error("swing did not stop");
  property p_hold; modeQ == 16'h0001 && traverseActive && !modeWr |=> traverseActive; endproperty
  a_hold: assert property (p_hold) else $error("swing ended while selected");
  property p_ampl; rdSet && regAddr == tfm_pkg::ADDR_AMPL |=> regRdata <= tfm_pkg::AMPL_MAX; endproperty
  a_ampl: assert property (p_ampl) else $error("amplitude above limit");
  property p_scr; rdSet && regAddr == tfm_pkg::ADDR_SCRAMBLE |=> regRdata <= tfm_pkg::SCRAMBLE_MAX; endproperty
  a_scr: assert property (p_scr) else $error("jump size above limit");
  property p_time; rdSet && regAddr inside {[4'h3:4'h4]} |=> regRdata inside {[16'h0001:16'h1770]}; endproperty
  a_time: assert property (p_time) else $error("ramp time out of range");
  property p_shift; rdSet && regAddr inside {[4'h5:4'h6]} |=> regRdata <= tfm_pkg::SHIFT_MAX; endproperty
  a_shift: assert property (p_shift) else $error("offset above limit");
  c_swing: cover property (traverseActive ##1 !traverseActive);
  c_term: cover property (termIn != '0 && !traverseActive);
  c_gate: cover property (rdSet && regAddr == tfm_pkg::ADDR_AMPL);
endmodule
bind tfm_traverse tfm_traverse_props #(.NTERM(NTERM), .FW(FW)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .termIn(termIn), .freqOut(freqOut), .traverseActive(traverseActive));
`default_nettype wire
